// ---- design/wrx_xfer_ctrl.sv ----
// wrx_xfer_ctrl: control-pin logic of the wireless power receiver.
// assumes all pin inputs are asynchronous; pull-downs live in the pad ring.
// Operation
// - floating control inputs read as low
// - both controls low enables wireless transfer
// - both high stops transfer, sends end code
// - resend end code on every ping
// - controls low again, ping restarts power
// - temperature pin can also terminate transfer
// - low indicator output during power transfer
// - wired detect low disables wired path
// - drive blocking switch enable for wired input
// - stop wireless output before enabling switch
// - wired present: answer ping with no power
// - after wired removal restart on next ping
// - wired start-up needs no transmitter
// - packets sent by load modulation pulses
// - control error packet every 250 ms
// - overshoot shortens packet interval to 32 ms
// - regulator off until rectifier converged
`timescale 1ns/10ps
module wrx_xfer_ctrl
  import wrx_pkg::*;
#(
  parameter int unsigned CE_SLOW = CE_SLOW_CYC,   // slow error interval
  parameter int unsigned CE_FAST = CE_FAST_CYC,   // fast error interval
  parameter int unsigned GAP     = WIRED_GAP_CYC  // dead time to switch
) (
  input  wire logic       clk_i,              // system clock
  input  wire logic       srst_i,             // synchronous reset
  input  wire logic       transfer_ctrl_a_i,  // host enable pin a
  input  wire logic       transfer_ctrl_b_i,  // host enable pin b
  input  wire logic       temp_sense_ctrl_i,  // thermistor comparator trip
  input  wire logic       wired_input_detect_i, // dc input above threshold
  input  wire logic       ping_i,             // transmitter ping powers us
  input  wire logic       rectifier_node_ok_i,          // rectifier at first target
  input  wire logic [7:0] ctrl_err_i,         // control error value
  input  wire logic       overshoot_i,        // large rectifier overshoot
  input  wire logic       mixed_stop_i,       // mixed controls terminate
  output logic            power_xfer_ind_n_o, // transfer indicator, low on
  output logic            wired_path_en_n_o,  // blocking switch, low on
  output logic            output_regulator_en_o, // regulator enable
  output logic            rectifier_node_mod_o,         // load modulation switch
  output logic            pkt_busy_o          // packet in flight
);
  // **************************************************
  // input synchronisers
  // **************************************************
  logic [SYNC_N-1:0] raw;
  logic [SYNC_N-1:0] meta;
  logic [SYNC_N-1:0] sync;
  logic              ping_d;

  // ping gets its own two-stage synchroniser plus a delay stage for the edge
  assign raw = {rectifier_node_ok_i, wired_input_detect_i, temp_sense_ctrl_i,
                transfer_ctrl_b_i, transfer_ctrl_a_i};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          meta[gi] <= 1'b0;
          sync[gi] <= 1'b0;
        end else begin
          meta[gi] <= raw[gi];
          sync[gi] <= meta[gi];
        end
      end
    end
  endgenerate

  logic ping_m;
  logic ping_s;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ping_m <= 1'b0;
      ping_s <= 1'b0;
      ping_d <= 1'b0;
    end else begin
      ping_m <= ping_i;
      ping_s <= ping_m;
      ping_d <= ping_s;
    end
  end

  // **************************************************
  // decode
  // **************************************************
  logic ca;
  logic cb;
  logic stop_req;
  logic wired;
  logic ping_rise;

  assign ca        = sync[SYNC_CTRL_A];
  assign cb        = sync[SYNC_CTRL_B];
  assign wired     = sync[SYNC_WIRED];
  assign ping_rise = ping_s & ~ping_d;
  // temp trip acts as a host stop; host keeps its gpio released otherwise
  assign stop_req  = (ca & cb) | sync[SYNC_TEMP]
                   | ((ca ^ cb) & mixed_stop_i);

  // **************************************************
  // state
  // **************************************************
  typedef struct packed {
    wrx_state_t       fsm;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] gap;
    logic             fast;
    logic             send;
    logic [7:0]       hdr;
    logic [7:0]       data;
    logic             ind_n;
    logic             wired_n;
    logic             reg_en;
  } wrx_st_t;

  wrx_st_t st;
  wrx_st_t next_st;
  logic    busy;

  always_comb begin
    next_st      = st;
    next_st.send = 1'b0;
    if (overshoot_i) begin
      next_st.fast = 1'b1;
    end
    unique case (st.fsm)
      WRX_IDLE: begin
        next_st.reg_en = 1'b0;
        if (wired) begin
          next_st.fsm = WRX_WIRED;
          next_st.gap = '0;
        end else if (ping_rise && stop_req) begin
          next_st.fsm  = WRX_TERMINATED;
          next_st.send = 1'b1;
          next_st.hdr  = HDR_EPT;
          next_st.data = EPT_CHARGE_DONE;
        end else if (ping_rise) begin
          next_st.fsm  = WRX_SETTLE;
          next_st.send = 1'b1;
          next_st.hdr  = HDR_WANT_POWER;
          next_st.data = 8'h00;
        end
      end
      WRX_SETTLE: begin
        if (wired) begin
          next_st.fsm = WRX_WIRED;
          next_st.gap = '0;
        end else if (stop_req) begin
          next_st.fsm  = WRX_TERMINATED;
          next_st.send = 1'b1;
          next_st.hdr  = HDR_EPT;
          next_st.data = EPT_CHARGE_DONE;
        end else if (sync[SYNC_RECTIFIER_NODE_OK]) begin
          next_st.fsm    = WRX_REGULATE;
          next_st.reg_en = 1'b1;
          next_st.ind_n  = 1'b0;
          next_st.cnt    = '0;
        end
      end
      WRX_REGULATE: begin
        next_st.cnt = st.cnt + 1'b1;
        if (wired) begin
          next_st.fsm    = WRX_WIRED;
          next_st.reg_en = 1'b0;
          next_st.ind_n  = 1'b1;
          next_st.gap    = '0;
        end else if (stop_req) begin
          next_st.fsm    = WRX_TERMINATED;
          next_st.reg_en = 1'b0;
          next_st.ind_n  = 1'b1;
          next_st.send   = 1'b1;
          next_st.hdr    = HDR_EPT;
          next_st.data   = EPT_CHARGE_DONE;
        end else if (st.cnt >= CNT_W'((st.fast ? CE_FAST : CE_SLOW) - 1)) begin
          next_st.cnt  = '0;
          next_st.fast = overshoot_i;
          next_st.send = 1'b1;
          next_st.hdr  = HDR_CTRL_ERR;
          next_st.data = ctrl_err_i;
        end
      end
      WRX_TERMINATED: begin
        // transmitter drops power and only pings until we ask again
        if (wired) begin
          next_st.fsm = WRX_WIRED;
          next_st.gap = '0;
        end else if (ping_rise && stop_req) begin
          next_st.send = 1'b1;
          next_st.hdr  = HDR_EPT;
          next_st.data = EPT_CHARGE_DONE;
        end else if (ping_rise) begin
          next_st.fsm  = WRX_SETTLE;
          next_st.send = 1'b1;
          next_st.hdr  = HDR_WANT_POWER;
          next_st.data = 8'h00;
        end
      end
      WRX_WIRED: begin
        next_st.reg_en = 1'b0;
        next_st.ind_n  = 1'b1;
        // dead time: neither source feeds the output, avoids back-flow
        if (st.gap < CNT_W'(GAP)) begin
          next_st.gap = st.gap + 1'b1;
        end else begin
          next_st.wired_n = 1'b0;
        end
        if (ping_rise) begin
          next_st.send = 1'b1;
          next_st.hdr  = HDR_NO_POWER;
          next_st.data = 8'h00;
        end
        if (!wired) begin
          next_st.fsm     = WRX_IDLE;
          next_st.wired_n = 1'b1;
        end
      end
    endcase
    // a packet still in flight drops the new request; it is not retried
    if (next_st.send && busy) begin
      next_st.send = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st         <= '0;
      st.fsm     <= WRX_IDLE;
      st.ind_n   <= 1'b1;
      st.wired_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // **************************************************
  // packet modulator
  // **************************************************
  wrx_modulator u_mod (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .start_i (st.send),
    .hdr_i   (st.hdr),
    .data_i  (st.data),
    .busy_o  (busy),
    .mod_o   (rectifier_node_mod_o)
  );

  assign pkt_busy_o            = busy;
  assign power_xfer_ind_n_o    = st.ind_n;
  assign wired_path_en_n_o     = st.wired_n;
  assign output_regulator_en_o = st.reg_en;
endmodule

// ---- design/wrx_pkg.sv ----
// wrx_pkg: shared constants and types of the receiver transfer control.
// assumes a 100 MHz clock; long timing counts are top-level parameters.
package wrx_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned CE_SLOW_MS      = 250;
  localparam int unsigned CE_FAST_MS      = 32;
  localparam int unsigned CE_SLOW_CYC     = CLK_HZ / 1000 * CE_SLOW_MS;
  localparam int unsigned CE_FAST_CYC     = CLK_HZ / 1000 * CE_FAST_MS;
  localparam int unsigned WIRED_GAP_US    = 1000;
  localparam int unsigned WIRED_GAP_CYC   = CLK_HZ / 1_000_000 * WIRED_GAP_US;
  localparam int unsigned CNT_W           = 25;
  localparam int unsigned PKT_BITS        = 8;
  localparam logic [7:0]  EPT_CHARGE_DONE = 8'h01;
  localparam logic [7:0]  HDR_EPT         = 8'h02;
  localparam logic [7:0]  HDR_CTRL_ERR    = 8'h03;
  localparam logic [7:0]  HDR_NO_POWER    = 8'h04;
  localparam logic [7:0]  HDR_WANT_POWER  = 8'h05;
  localparam int unsigned SYNC_N          = 5;
  localparam int unsigned SYNC_CTRL_A     = 0;
  localparam int unsigned SYNC_CTRL_B     = 1;
  localparam int unsigned SYNC_TEMP       = 2;
  localparam int unsigned SYNC_WIRED      = 3;
  localparam int unsigned SYNC_RECTIFIER_NODE_OK    = 4;

  typedef enum logic [2:0] {
    WRX_IDLE, WRX_SETTLE, WRX_REGULATE, WRX_TERMINATED, WRX_WIRED
  } wrx_state_t;
endpackage

// ---- design/wrx_modulator.sv ----
// wrx_modulator: shifts a two-byte packet out as load-modulation pulses.
// assumes start_i is a one-cycle pulse taken only while busy_o is low.
`timescale 1ns/10ps
module wrx_modulator
  import wrx_pkg::*;
(
  input  wire logic       clk_i,    // system clock
  input  wire logic       srst_i,   // synchronous reset
  input  wire logic       start_i,  // send request pulse
  input  wire logic [7:0] hdr_i,    // packet header byte
  input  wire logic [7:0] data_i,   // packet payload byte
  output logic            busy_o,   // packet in flight
  output logic            mod_o     // load modulation switch
);
  typedef struct packed {
    logic [15:0] shreg;
    logic [4:0]  left;
    logic        mod;
    logic        busy;
  } wrx_mod_st_t;

  wrx_mod_st_t st;
  wrx_mod_st_t next_st;

  // first bit leaves with busy so the frame and the bits line up
  always_comb begin
    next_st     = st;
    next_st.mod = 1'b0;
    if (st.busy) begin
      next_st.left = st.left - 5'h01;
      if (st.left == 5'h01) begin
        next_st.busy = 1'b0;
      end else begin
        next_st.mod   = st.shreg[15];
        next_st.shreg = {st.shreg[14:0], 1'b0};
      end
    end else if (start_i) begin
      next_st.busy  = 1'b1;
      next_st.mod   = hdr_i[7];
      next_st.shreg = {hdr_i[6:0], data_i, 1'b0};
      next_st.left  = 5'(2 * PKT_BITS);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy_o = st.busy;
  assign mod_o  = st.mod;
endmodule

// ---- bench/wrx_xfer_ctrl_asserts.sv ----
// wrx_xfer_ctrl_asserts: port checks of the receiver transfer control.
// assumes binding to wrx_xfer_ctrl; one clock, synchronous reset.
`timescale 1ns/10ps
module wrx_xfer_ctrl_asserts #(
  parameter int unsigned GAP = 10  // dead time before switch
) (
  input  wire logic clk_i,                 // system clock
  input  wire logic srst_i,                // synchronous reset
  input  wire logic transfer_ctrl_a_i,     // host enable a
  input  wire logic transfer_ctrl_b_i,     // host enable b
  input  wire logic wired_input_detect_i,  // dc input present
  input  wire logic ping_i,                // transmitter ping
  input  wire logic rectifier_node_ok_i,             // rectifier converged
  input  wire logic power_xfer_ind_n_o,    // indicator, low on
  input  wire logic wired_path_en_n_o,     // switch, low on
  input  wire logic output_regulator_en_o, // regulator enable
  input  wire logic pkt_busy_o             // packet in flight
);
  // ****************************************
  // helper counters and checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic [4:0]  busy_cnt;
  logic [15:0] off_cnt;
  // off_cnt saturates so a long idle never wraps into a false gap
  always_ff @(posedge clk_i) begin
    if (srst_i || !pkt_busy_o) busy_cnt <= 5'h00;
    else busy_cnt <= busy_cnt + 5'h01;
    if (srst_i || output_regulator_en_o) off_cnt <= 16'h0000;
    else if (off_cnt != 16'hFFFF) off_cnt <= off_cnt + 16'h0001;
  end
  property p_ind_reg; !power_xfer_ind_n_o |-> output_regulator_en_o;
  endproperty
  a_ind_reg: assert property (p_ind_reg)
    else $error("indicator on without regulator");
  property p_stop_ab; (transfer_ctrl_a_i && transfer_ctrl_b_i) [*5]
    |=> power_xfer_ind_n_o && !output_regulator_en_o; endproperty
  a_stop_ab: assert property (p_stop_ab)
    else $error("transfer kept with both controls high");
  property p_wired_idle; !wired_input_detect_i [*5] |=> wired_path_en_n_o;
  endproperty
  a_wired_idle: assert property (p_wired_idle)
    else $error("switch on without wired input");
  property p_wired_reg; wired_input_detect_i [*5] |=> !output_regulator_en_o;
  endproperty
  a_wired_reg: assert property (p_wired_reg)
    else $error("regulator on with wired input");
  property p_gap; $fell(wired_path_en_n_o) |-> 32'(off_cnt) >= GAP;
  endproperty
  a_gap: assert property (p_gap)
    else $error("switch on before dead time");
  property p_reg_rectifier_node; $rose(output_regulator_en_o) |-> $past(rectifier_node_ok_i, 3);
  endproperty
  a_reg_rectifier_node: assert property (p_reg_rectifier_node)
    else $error("regulator on before rectifier settled");
  property p_busy_len; $fell(pkt_busy_o) |-> busy_cnt == 5'h10; endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("packet not sixteen cycles");
  property p_ept_ping; (transfer_ctrl_a_i && transfer_ctrl_b_i) [*8] ##1
    $rose(ping_i) |-> ##[1:8] pkt_busy_o; endproperty
  a_ept_ping: assert property (p_ept_ping)
    else $error("ping not answered while stopped");
endmodule

// ---- bench/wrx_tx_model.sv ----
// wrx_tx_model: transmitter across the coils; pings and decodes packets.
// assumes packets framed by the busy flag, header byte first, msb first.
`timescale 1ns/10ps
module wrx_tx_model
  import wrx_pkg::*;
#(
  parameter int unsigned PING_PER = 300  // ping spacing, scaled down
) (
  input  wire logic        clk_i,   // system clock
  input  wire logic        srst_i,  // synchronous reset
  input  wire logic        mod_i,   // load modulation seen on coil
  input  wire logic        busy_i,  // packet framing
  output logic             ping_o,  // ping that powers the receiver
  output logic [15:0]      pkt_o,   // last packet decoded
  output logic [7:0]       cnt_o    // packets decoded
);
  // ****************************************
  // probing and demodulation
  // ****************************************
  logic [15:0] sh;
  logic        busy_q;
  logic        engaged;
  logic        done;
  int unsigned tmr;
  assign done   = busy_q && !busy_i;
  assign ping_o = !engaged && tmr < 4;
  always_ff @(posedge clk_i) begin
    busy_q <= busy_i && !srst_i;
    if (busy_i) sh <= {sh[14:0], mod_i};
    if (srst_i) begin
      cnt_o   <= 8'h00;
      engaged <= 1'b0;
      tmr     <= 0;
    end else begin
      if (done) cnt_o <= cnt_o + 8'h01;
      if (done) pkt_o <= sh;
      // power only on request; any report but a control error drops it
      if (done && sh[15:8] == HDR_WANT_POWER) engaged <= 1'b1;
      else if (done && sh[15:8] != HDR_CTRL_ERR) engaged <= 1'b0;
      else if (tmr >= 2 * PING_PER) engaged <= 1'b0;
      if ((done && engaged) || tmr >= (engaged ? 2 : 1) * PING_PER)
        tmr <= 0;
      else tmr <= tmr + 1;
    end
  end
endmodule

// ---- bench/testbench.sv ----
// testbench: host pins and a transmitter model around the transfer control.
// assumes shortened timing parameters; every wait is bounded.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module testbench
  import wrx_pkg::*;
;
  // ****************************************
  // stimulus and checks
  // ****************************************
  localparam int unsigned CE_S = 200;
  localparam int unsigned CE_F = 40;
  localparam int unsigned GP   = 10;
  logic        clk_i = 1'b0, srst_i = 1'b1;
  logic        ctl_a = 1'b0, ctl_b = 1'b0, temp = 1'b0, wired = 1'b0;
  logic        rectifier_node_ok = 1'b0, ovs = 1'b0, mix = 1'b0, ping;
  logic [7:0]  ctrl_err = 8'h5A, cnt;
  logic [15:0] pkt;
  logic        ind_n, wpn, reg_en, mod, busy;
  logic [3:0]  stops [3] = '{4'hC, 4'h5, 4'h2};
  int          fails = 0, checked = 0, cyc = 0, t0;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  wrx_xfer_ctrl #(.CE_SLOW(CE_S), .CE_FAST(CE_F), .GAP(GP)) dut_u (
    .clk_i(clk_i), .srst_i(srst_i), .transfer_ctrl_a_i(ctl_a),
    .transfer_ctrl_b_i(ctl_b), .temp_sense_ctrl_i(temp),
    .wired_input_detect_i(wired), .ping_i(ping), .rectifier_node_ok_i(rectifier_node_ok),
    .ctrl_err_i(ctrl_err), .overshoot_i(ovs), .mixed_stop_i(mix),
    .power_xfer_ind_n_o(ind_n), .wired_path_en_n_o(wpn),
    .output_regulator_en_o(reg_en), .rectifier_node_mod_o(mod), .pkt_busy_o(busy));
  wrx_tx_model #(.PING_PER(300)) tx_u (.clk_i(clk_i), .srst_i(srst_i),
    .mod_i(mod), .busy_i(busy), .ping_o(ping), .pkt_o(pkt), .cnt_o(cnt));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic print_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // header 8'hFF accepts any packet
  task automatic wait_pkt(input logic [7:0] h);
    logic [7:0] c;
    c = cnt;
    for (int i = 0; i < 4000; i++) begin
      tick(1);
      if (cnt !== c && (h === 8'hFF || pkt[15:8] === h)) return;
      c = cnt;
    end
    `CHK("packet wait", h, 8'h00)
    print_verdict();
  endtask
  initial begin
    tick(20);
    srst_i = 1'b0;
    `CHK("ind_n", 1'b1, ind_n)
    `CHK("wired_n", 1'b1, wpn)
    `CHK("busy", 1'b0, busy)
    // wired input before any transmitter has engaged
    wired = 1'b1;
    tick(GP + 8);
    `CHK("wired_n", 1'b0, wpn)
    `CHK("reg_en", 1'b0, reg_en)
    wired = 1'b0;
    wait_pkt(8'hFF);
    `CHK("reg_en", 1'b0, reg_en)
    rectifier_node_ok = 1'b1;
    tick(8);
    `CHK("reg_en", 1'b1, reg_en)
    `CHK("ind_n", 1'b0, ind_n)
    wait_pkt(HDR_CTRL_ERR);
    t0 = cyc;
    wait_pkt(HDR_CTRL_ERR);
    `CHK("ce pkt", {HDR_CTRL_ERR, 8'h5A}, pkt)
    `CHK("slow gap", 1'b1, cyc - t0 inside {[CE_S-4:CE_S+20]})
    ovs = 1'b1;
    wait_pkt(HDR_CTRL_ERR);
    wait_pkt(HDR_CTRL_ERR);
    t0 = cyc;
    wait_pkt(HDR_CTRL_ERR);
    ovs = 1'b0;
    `CHK("fast gap", 1'b1, cyc - t0 inside {[CE_F-4:CE_F+20]})
    ctl_a = 1'b1;
    tick(8);
    `CHK("ind_n mixed", 1'b0, ind_n)
    // stop causes: both controls, mixed with stop set, thermal trip
    for (int k = 0; k < 3; k++) begin
      {ctl_a, ctl_b, temp, mix} = stops[k];
      wait_pkt(HDR_EPT);
      `CHK("end pkt", {HDR_EPT, EPT_CHARGE_DONE}, pkt)
      `CHK("ind_n", 1'b1, ind_n)
      `CHK("reg_en", 1'b0, reg_en)
      wait_pkt(HDR_EPT);
      `CHK("resend", {HDR_EPT, EPT_CHARGE_DONE}, pkt)
      {ctl_a, ctl_b, temp, mix} = 4'h0;
      wait_pkt(HDR_WANT_POWER);
      tick(8);
      `CHK("reg_en", 1'b1, reg_en)
    end
    wired = 1'b1;
    tick(4);
    `CHK("reg_en", 1'b0, reg_en)
    tick(GP + 8);
    `CHK("wired_n", 1'b0, wpn)
    wait_pkt(HDR_NO_POWER);
    `CHK("reg_en", 1'b0, reg_en)
    wired = 1'b0;
    tick(6);
    `CHK("wired_n", 1'b1, wpn)
    wait_pkt(HDR_WANT_POWER);
    tick(8);
    `CHK("reg_en", 1'b1, reg_en)
    print_verdict();
  end
endmodule
bind wrx_xfer_ctrl wrx_xfer_ctrl_asserts #(.GAP(GAP)) chk_u (.clk_i,
  .srst_i, .transfer_ctrl_a_i, .transfer_ctrl_b_i, .wired_input_detect_i,
  .ping_i, .rectifier_node_ok_i, .power_xfer_ind_n_o, .wired_path_en_n_o,
  .output_regulator_en_o, .pkt_busy_o);
